// ### common/dps_pkg.sv
// constants and types shared by the dual-port memory host controller
//
// How it works
// - A port is selected only while its low-active enable is low and its high-active enable is high.
// - Depth is widened by decoding upper address bits onto the two enables of each device.
// - Wider words come from devices side by side, one master, the rest slaves, busy lines joined.
// - Four low-active byte selects on the left port gate which bytes are read or written.
package dps_pkg;
   localparam int DATA_W     = 36;   // word width
   localparam int LANES      = 4;    // byte select lanes
   localparam int ADDR_W_32K = 15;   // address width of the deeper variant
   localparam int ADDR_W_16K = 14;   // address width of the smaller variant
   localparam int CLK_NS     = 5;    // clock period
   localparam int ACCESS_NS  = 20;   // slowest grade access time, ns
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;   // least time, rounded up
   localparam int SYNC_LAT   = 3;    // pin synchroniser depth
   localparam int CNT_W      = 8;    // access counter width
   localparam logic RW_READ  = 1'b1; // read/write select level for a read
   localparam logic RW_WRITE = 1'b0; // read/write select level for a write

   typedef enum logic [1:0] {
      DPS_IDLE    = 2'b00,
      DPS_ACCESS  = 2'b01,
      DPS_RECOVER = 2'b10
   } dps_state_t;
endpackage : dps_pkg

// ### rtl/dps_sync.sv
// three-stage pin synchroniser, output moves once stages two and three agree
`timescale 1ns/1ps
module dps_sync #(
   parameter int         W   = 1,         // bus width
   parameter logic [W-1:0] RST = '0       // reset value
) (
   input  wire logic         clk,         // system clock
   input  wire logic         resetn,      // synchronous reset, active low
   input  wire logic [W-1:0] d,           // asynchronous pin level
   output logic      [W-1:0] q            // filtered, synchronised level
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // s1 feeds only s2; q follows once s2 and s3 agree
   always_ff @(posedge clk) begin
      if (!resetn) begin
         s1 <= RST;
         s2 <= RST;
         s3 <= RST;
         q  <= RST;
      end else begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            q <= s3;
         end
      end
   end
endmodule : dps_sync

// ### rtl/dps_host.sv
// host controller driving the left port of the dual-port memory through its pins
`timescale 1ns/1ps
module dps_host
   import dps_pkg::*;
#(
   parameter int ADDR_W    = ADDR_W_32K,   // device address width
   parameter int BANK_BITS = 1,            // upper address bits decoded onto device enables
   parameter int NBANK     = 2 ** BANK_BITS
) (
   input  wire logic                 clk,                      // system clock
   input  wire logic                 resetn,                   // synchronous reset, active low
   // user side
   input  wire logic                 cmd_valid,                // access request
   output logic                      cmd_ready,                // controller idle
   input  wire logic                 cmd_write,                // 1 write, 0 read
   input  wire logic                 cmd_token,                // 1 token latch, 0 array
   input  wire logic [BANK_BITS-1:0] cmd_bank,                 // device selected by upper bits
   input  wire logic [ADDR_W-1:0]    cmd_addr,                 // word address in device
   input  wire logic [DATA_W-1:0]    cmd_wdata,                // write data
   input  wire logic [LANES-1:0]     cmd_byte_en,              // byte enables, active high
   output logic                      rsp_valid,                // one-cycle completion pulse
   output logic [DATA_W-1:0]         rsp_rdata,                // read data
   output logic                      rsp_collided,             // busy was seen at the last count of an access
   output logic                      mailbox_pending,          // far side posted mailbox event
   // device pins
   output logic [ADDR_W-1:0]         left_addr,                // address pins
   output logic [NBANK-1:0]          left_select_low_active,   // low-active enables per device
   output logic [NBANK-1:0]          left_select_high_active,  // high-active enables per device
   output logic                      left_read_write_select,   // 1 read, 0 write
   output logic                      left_output_enable_n,     // device output enable, low
   output logic [LANES-1:0]          left_byte_lane_selects,   // byte selects, low active
   output logic [NBANK-1:0]          left_token_latch_enable,  // token enable per device, low
   output logic [DATA_W-1:0]         left_data_out,            // data bus drive value
   output logic                      left_data_oe,             // high while host drives bus
   input  wire logic [DATA_W-1:0]    left_data_in,             // data bus level
   input  wire logic                 left_busy_n,              // joined busy line, low active
   input  wire logic                 left_mailbox_flag         // mailbox flag pin, low active
);
   // last count of a timed access: access time plus the synchroniser delay on returned data
   localparam logic [CNT_W-1:0] LAST   = CNT_W'(ACCESS_CYC + SYNC_LAT - 1);
   localparam int               LANE_W = DATA_W / LANES;   // bits per byte lane

   // one-hot device decode from upper address bits
   function automatic logic [NBANK-1:0] bank_hot(input logic [BANK_BITS-1:0] b);
      bank_hot = NBANK'(1) << b;
   endfunction : bank_hot

   // sequencer state, access counter and synchronised pins
   dps_state_t        state;
   dps_state_t        next_state;
   logic [CNT_W-1:0]  cnt;
   logic              is_write;
   logic [DATA_W-1:0] data_s;
   logic              busy_n_s;
   logic              mbox_n_s;

   // pin inputs through three-stage synchronisers
   dps_sync #(.W(DATA_W), .RST('0)) u_sync_data (
      .clk    (clk),
      .resetn (resetn),
      .d      (left_data_in),
      .q      (data_s)
   );
   // busy is the line shared by devices side by side; both flags idle high
   dps_sync #(.W(2), .RST(2'h3)) u_sync_flags (
      .clk    (clk),
      .resetn (resetn),
      .d      ({left_busy_n, left_mailbox_flag}),
      .q      ({busy_n_s, mbox_n_s})
   );

   // decode of request acceptance and access end
   wire take      = (state == DPS_IDLE) && cmd_ready && cmd_valid;
   wire at_last   = (state == DPS_ACCESS) && (cnt == LAST);
   wire busy_now  = !busy_n_s;
   wire retry     = at_last && busy_now;
   wire finish    = at_last && !busy_now;
   wire [NBANK-1:0] hot = bank_hot(cmd_bank);

   // next state; recover keeps the port deselected for one cycle between accesses
   always_comb begin
      next_state = state;
      unique case (state)
         DPS_IDLE: begin
            if (take) begin
               next_state = DPS_ACCESS;
            end
         end
         DPS_ACCESS: begin
            if (finish) begin
               next_state = DPS_RECOVER;
            end
         end
         DPS_RECOVER: begin
            next_state = DPS_IDLE;
         end
         default: begin
            next_state = DPS_IDLE;   // unused code 2'b11
         end
      endcase
   end

   // state and access counter; busy restarts the timed access
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state <= DPS_IDLE;
         cnt   <= '0;
      end else begin
         state <= next_state;
         cnt   <= (take || retry) ? '0 : cnt + CNT_W'(1);
      end
   end

   // pin drive: enables asserted for the whole access, released on finish
   always_ff @(posedge clk) begin
      if (!resetn) begin
         left_addr               <= '0;
         left_select_low_active  <= '1;
         left_select_high_active <= '0;
         left_token_latch_enable <= '1;
         left_read_write_select  <= RW_READ;
         left_output_enable_n    <= 1'b1;
         left_byte_lane_selects  <= '1;
         left_data_out           <= '0;
         left_data_oe            <= 1'b0;
         is_write                <= 1'b0;
      end else if (take) begin
         left_addr               <= cmd_addr;
         left_select_low_active  <= cmd_token ? '1 : ~hot;
         left_select_high_active <= cmd_token ? '0 : hot;
         left_token_latch_enable <= cmd_token ? ~hot : '1;
         left_read_write_select  <= cmd_write ? RW_WRITE : RW_READ;
         left_output_enable_n    <= cmd_write;
         left_byte_lane_selects  <= ~cmd_byte_en;
         left_data_out           <= cmd_wdata;
         left_data_oe            <= cmd_write;
         is_write                <= cmd_write;
      end else if (finish) begin
         left_select_low_active  <= '1;
         left_select_high_active <= '0;
         left_token_latch_enable <= '1;
         left_read_write_select  <= RW_READ;
         left_output_enable_n    <= 1'b1;
         left_byte_lane_selects  <= '1;
         left_data_oe            <= 1'b0;
      end
   end

   // user answers; read lanes not enabled come back as zero
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cmd_ready       <= 1'b0;
         rsp_valid       <= 1'b0;
         rsp_rdata       <= '0;
         rsp_collided    <= 1'b0;
         mailbox_pending <= 1'b0;
      end else begin
         cmd_ready       <= (next_state == DPS_IDLE);
         rsp_valid       <= finish;
         mailbox_pending <= !mbox_n_s;
         if (take) begin
            rsp_collided <= 1'b0;
         end else if (retry) begin
            rsp_collided <= 1'b1;
         end
         if (finish && !is_write) begin
            for (int i = 0; i < LANES; i++) begin
               rsp_rdata[i*LANE_W +: LANE_W] <= left_byte_lane_selects[i] ? '0 :
                                                data_s[i*LANE_W +: LANE_W];
            end
         end
      end
   end

   // checks on pin behaviour
   a_bank_onehot: assert property (@(posedge clk) disable iff (!resetn)
      $onehot0(~left_select_low_active & left_select_high_active))
      else $error("more than one device selected");
   a_token_apart: assert property (@(posedge clk) disable iff (!resetn)
      (left_token_latch_enable != '1) |-> (left_select_low_active == '1))
      else $error("token access with array enabled");
   a_lanes_idle: assert property (@(posedge clk) disable iff (!resetn)
      (state == DPS_IDLE) |-> (left_byte_lane_selects == '1 && !left_data_oe))
      else $error("byte selects or bus driven while idle");
   a_busy_hold: assert property (@(posedge clk) disable iff (!resetn)
      (retry && is_write) |=> (state == DPS_ACCESS && left_data_oe && cnt == '0)
      ##1 (state == DPS_ACCESS && left_data_oe && cnt == CNT_W'(1)))
      else $error("write released while busy");
   a_access_len: assert property (@(posedge clk) disable iff (!resetn)
      take |=> (state == DPS_ACCESS) [*6])
      else $error("access shorter than timed length");
   a_done_release: assert property (@(posedge clk) disable iff (!resetn)
      rsp_valid |-> ($past(at_last) && left_select_low_active == '1 && !left_data_oe))
      else $error("completion without release");

   // checks on access sequencing and bus ownership
   a_pins_stable: assert property (@(posedge clk) disable iff (!resetn)
      (state == DPS_ACCESS && $past(state) == DPS_ACCESS) |->
      ($stable(left_addr) && $stable(left_select_low_active) && $stable(left_byte_lane_selects)))
      else $error("pins moved during an access");
   a_write_drive: assert property (@(posedge clk) disable iff (!resetn)
      (state == DPS_ACCESS && is_write) |-> (left_data_oe && left_output_enable_n))
      else $error("write without bus drive or with outputs enabled");
   a_read_quiet: assert property (@(posedge clk) disable iff (!resetn)
      (state == DPS_ACCESS && !is_write) |-> (!left_data_oe && left_read_write_select == RW_READ))
      else $error("host drives the bus during a read");
   a_select_one: assert property (@(posedge clk) disable iff (!resetn)
      (state == DPS_ACCESS) |->
      $onehot((~left_select_low_active & left_select_high_active) | ~left_token_latch_enable))
      else $error("access without exactly one device enabled");
   a_rsp_pulse: assert property (@(posedge clk) disable iff (!resetn)
      rsp_valid |=> !rsp_valid)
      else $error("completion pulse longer than one cycle");
   a_ready_idle: assert property (@(posedge clk) disable iff (!resetn)
      cmd_ready |-> (state == DPS_IDLE && left_select_high_active == '0))
      else $error("ready while a device is selected");
   a_collide_clear: assert property (@(posedge clk) disable iff (!resetn)
      take |=> !rsp_collided)
      else $error("collision flag carried into a new access");

   c_read:  cover property (@(posedge clk) disable iff (!resetn) take && !cmd_write && !cmd_token);
   c_write: cover property (@(posedge clk) disable iff (!resetn) take && cmd_write);
   c_token: cover property (@(posedge clk) disable iff (!resetn) take && cmd_token);
   c_retry: cover property (@(posedge clk) disable iff (!resetn) retry);
   c_mailbox: cover property (@(posedge clk) disable iff (!resetn) mailbox_pending);
endmodule : dps_host

// ### tb/dps_dev_model.sv
// behavioural model of one memory device seen from its left port
`timescale 1ns/1ps
module dps_dev_model (
   input  wire logic        clk,     // bench clock, marks event times
   input  wire logic [14:0] addr,    // address pins
   input  wire logic        sel_lo,  // low-active enable
   input  wire logic        sel_hi,  // high-active enable
   input  wire logic        tok_n,   // token latch enable, low
   input  wire logic        rw,      // 1 read, 0 write
   input  wire logic        oe_n,    // output enable, low
   input  wire logic [3:0]  bsel_n,  // byte selects, low
   input  wire logic [35:0] bus,     // resolved data bus
   output logic      [35:0] dout,    // read data, inverse of last when released
   output logic             drv      // high while this device drives the bus
);
   logic [35:0] mem [logic [14:0]];
   logic [7:0]  tok = 8'h00;
   logic [35:0] last = 36'h0;
   wire         sel = !sel_lo && sel_hi;
   wire         rd  = (sel || !tok_n) && rw && !oe_n;
   // writes land each edge of an active write; a released bus shows the inverse of the last word
   always @(posedge clk) begin
      if (!rw && !tok_n) tok[addr[2:0]] = bus[0];
      if (!rw && sel) begin
         if (!mem.exists(addr)) mem[addr] = 36'h0;
         for (int i = 0; i < 4; i++) begin
            if (!bsel_n[i]) mem[addr][9*i+:9] = bus[9*i+:9];
         end
      end
      if (rd) last = !tok_n ? {35'h0, tok[addr[2:0]]} : mem.exists(addr) ? mem[addr] : 36'h0;
      drv  <= rd;
      dout <= rd ? last : ~last;
   end
endmodule : dps_dev_model

// ### tb/dps_host_test.sv
// self-checking bench for the dual-port memory host controller
`timescale 1ns/1ps
module dps_host_test
   import dps_pkg::*;
;
   logic        clk = 1'b0, resetn = 1'b0;
   logic        cmd_valid = 1'b0, cmd_write = 1'b0, cmd_token = 1'b0;
   logic [0:0]  cmd_bank = 1'b0;
   logic [14:0] cmd_addr = '0, left_addr;
   logic [35:0] cmd_wdata = '0, rsp_rdata, left_data_out, bus;
   logic [3:0]  cmd_byte_en = '0, bsel_n;
   logic        left_busy_n = 1'b1, left_mailbox_flag = 1'b1;
   logic        cmd_ready, rsp_valid, rsp_collided, mailbox_pending;
   logic        rw, oe_n, left_data_oe;
   logic [1:0]  sel_lo, sel_hi, tok_n, drv;
   logic [71:0] dev_out;
   bit   [35:0] ref_mem [int];
   bit          tok_ref [int];
   int          num_errors = 0, n_checks = 0;
   initial forever #2.5 clk = ~clk;
   // host drive wins, else whichever device drives
   assign bus = left_data_oe ? left_data_out : drv[1] ? dev_out[71:36] : dev_out[35:0];
   dps_host u_dut (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_write(cmd_write), .cmd_token(cmd_token), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_byte_en(cmd_byte_en), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .rsp_collided(rsp_collided), .mailbox_pending(mailbox_pending),
      .left_addr(left_addr), .left_select_low_active(sel_lo), .left_select_high_active(sel_hi),
      .left_read_write_select(rw), .left_output_enable_n(oe_n), .left_byte_lane_selects(bsel_n),
      .left_token_latch_enable(tok_n), .left_data_out(left_data_out),
      .left_data_oe(left_data_oe), .left_data_in(bus), .left_busy_n(left_busy_n),
      .left_mailbox_flag(left_mailbox_flag));
   // two devices stacked in depth, one per decoded bank
   dps_dev_model u_dev [1:0] (.clk(clk), .addr(left_addr), .sel_lo(sel_lo), .sel_hi(sel_hi),
      .tok_n(tok_n), .rw(rw), .oe_n(oe_n), .bsel_n(bsel_n), .bus(bus), .dout(dev_out),
      .drv(drv));
   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input string what, input logic [35:0] exp, got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // one cycle wait with a bound; running out ends the run
   task automatic wait_tick(inout int n);
      @(negedge clk);
      n++;
      if (n > 200) begin
         num_errors++;
         $display("wrong value wait bound expected done seen hang");
         end_of_test();
      end
   endtask : wait_tick
   // one access; bz cycles of busy stand for the far port on the same word
   task automatic access(input logic w, tk, bk, input logic [14:0] a,
                         input logic [35:0] d, input logic [3:0] be, input int bz);
      int          n;
      logic [35:0] m;
      logic [1:0]  one;
      n = 0;
      m = {{9{be[3]}}, {9{be[2]}}, {9{be[1]}}, {9{be[0]}}};
      one = bk ? 2'b10 : 2'b01;
      while (cmd_ready !== 1'b1) wait_tick(n);
      {cmd_valid, cmd_write, cmd_token, cmd_bank, cmd_addr, cmd_wdata, cmd_byte_en} =
         {1'b1, w, tk, bk, a, d, be};
      left_busy_n = (bz == 0);
      @(negedge clk);
      cmd_valid = 1'b0;
      @(negedge clk);
      chk("pins", {tk ? 2'b11 : ~one, tk ? 2'b00 : one, tk ? ~one : 2'b11, ~w, w, ~be, a},
          {sel_lo, sel_hi, tok_n, rw, oe_n, bsel_n, left_addr});
      while (rsp_valid !== 1'b1) begin
         wait_tick(n);
         if (n == bz) left_busy_n = 1'b1;
      end
      chk("idle pins", 6'b110011, {sel_lo, sel_hi, tok_n});
      chk("collided", bz > 0, rsp_collided);
      if (tk && w) tok_ref[{bk, a[2:0]}] = d[0];
      else if (tk) chk("token", {35'h0, tok_ref[{bk, a[2:0]}]} & m, rsp_rdata);
      else if (w) ref_mem[{bk, a}] = (ref_mem[{bk, a}] & ~m) | (d & m);
      else chk("rdata", ref_mem[{bk, a}] & m, rsp_rdata);
   endtask : access
   // main sequence: reset, array traffic, token latches, mailbox
   initial begin
      int a;
      void'($urandom(4));
      repeat (20) @(negedge clk);
      chk("reset", 7'b0110011, {cmd_ready, sel_lo, sel_hi, tok_n});
      resetn = 1'b1;
      for (int i = 0; i < 16; i++) begin
         a = (i < 2) ? 32'h7FFF * i : $urandom;
         access(1'b1, 1'b0, i[0], a[14:0], 36'({$urandom, $urandom}), 4'($urandom),
                (i % 4 == 1) ? 12 : 0);
         access(1'b0, 1'b0, i[0], a[14:0], 36'h0, (i % 3 == 0) ? 4'hF : 4'($urandom),
                (i % 4 == 3) ? 12 : 0);
      end
      // reset again mid run; the next access must wait for ready once more
      resetn = 1'b0;
      repeat (2) @(negedge clk);
      chk("reset", 7'b0110011, {cmd_ready, sel_lo, sel_hi, tok_n});
      resetn = 1'b1;
      for (int t = 0; t < 16; t++) begin
         access(1'b1, 1'b1, t[3], 15'(t), 36'($urandom), 4'hF, 0);
         access(1'b0, 1'b1, t[3], 15'(t), 36'h0, 4'hF, 0);
      end
      // mailbox pin passes the four synchroniser flops and the flag register
      for (int k = 0; k < 2; k++) begin
         left_mailbox_flag = k[0];
         repeat (SYNC_LAT + 1) @(negedge clk);
         chk("mailbox early", k[0], mailbox_pending);
         @(negedge clk);
         chk("mailbox", !k[0], mailbox_pending);
      end
      end_of_test();
   end
endmodule : dps_host_test
